// >>> ras_map.vh
// register offsets, field positions, reset values and vectors for the return address stack unit
// assumes a byte-wide register port with a 3-bit word address
`ifndef RAS_MAP_VH
`define RAS_MAP_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RAS_OFS_PTR 3'h0
`define RAS_OFS_TOP_LOW 3'h1
`define RAS_OFS_TOP_HIGH 3'h2
`define RAS_OFS_TOP_UPPER 3'h3
`define RAS_OFS_PC_LOW 3'h4
`define RAS_OFS_PC_HIGH_LATCH 3'h5
`define RAS_OFS_PC_UPPER_LATCH 3'h6
`define RAS_OFS_CTRL 3'h7

// ----------------------------------------
// field positions
// ----------------------------------------
`define RAS_PTR_FULL_BIT 7
`define RAS_PTR_UNF_BIT 6
`define RAS_CTRL_OVF_RST_BIT 0
`define RAS_CTRL_SW_PUSH_BIT 1
`define RAS_CTRL_SW_POP_BIT 2

// ----------------------------------------
// sizes, reset values and vectors
// ----------------------------------------
`define RAS_PC_W 21
`define RAS_PTR_W 5
`define RAS_PTR_TOP 5'h1F
`define RAS_PTR_LAST_FREE 5'h1E
`define RAS_PTR_RST 5'h00
`define RAS_PC_RST 21'h000000
`define RAS_PC_STEP 21'h000002
`define RAS_VEC_RESET 21'h000000
`define RAS_VEC_INT_HIGH 21'h000008
`define RAS_VEC_INT_LOW 21'h000018
`define RAS_OVF_RST_EN_RST 1'h1
`define RAS_MEM_32K 21'h008000
`define RAS_MEM_16K 21'h004000

`endif

// >>> stack_storage.v
// 31 x 21-bit return stack storage in flip-flops, entries 1..31
// assumes the caller never writes index 0; index 0 reads as zero
module stack_storage
(
	input wire core_clk,
	input wire wrEn,
	input wire [4:0] wrIdx,
	input wire [20:0] wrData,
	input wire [4:0] rdIdx,
	output wire [20:0] rdData
);

	// ----------------------------------------
	// entry array
	// ----------------------------------------
	wire [20:0] entryQ [0:31];

	// no storage stands behind index 0, it is only the empty state
	assign entryQ[0] = 21'h000000;

	// one flop row per entry; storage is not reset, like a ram
	genvar gi;
	generate
		for (gi = 1; gi < 32; gi = gi + 1)
		begin : gEntry
			reg [20:0] entry_ff;
			always @(posedge core_clk)
			begin
				if (wrEn && ({27'h0000000, wrIdx} == gi))
					entry_ff <= wrData;
			end
			assign entryQ[gi] = entry_ff;
		end
	endgenerate

	// top entry read by index
	assign rdData = entryQ[rdIdx];

endmodule // stack_storage

// >>> fetch_gate.v
// program fetch path: passes the memory word for implemented addresses, zero above them
// assumes the memory answers combinationally on its own bus, apart from data space
`include "ras_map.vh"

module fetch_gate
#(
	parameter [20:0] MEM_BYTES = `RAS_MEM_32K
)
(
	input wire [20:0] fetchAddr,
	input wire [15:0] memWord,
	output wire [15:0] fetchWord
);

	// ----------------------------------------
	// range check
	// ----------------------------------------
	// words above the implemented size read as all zero, a no-operation
	wire inRange;
	assign inRange = (fetchAddr < MEM_BYTES);
	assign fetchWord = inRange ? memWord : 16'h0000;

endmodule // fetch_gate

// >>> return_address_stack_unit.v
// return address stack and program counter for an 8-bit core
// assumes the sequencer raises at most one of its strobes per cycle and
// that software uses a byte-wide register port with one-cycle strobes
//
// Overview of operation
// - program counter is 21 bits, covering the whole 2-Mbyte space
// - fetches above implemented memory return all zeros
// - implemented memory size is a parameter: 32 or 16 Kbytes
// - counter starts at 0000h; interrupts vector to 0008h or 0018h
// - calls and acknowledged interrupts push the program counter
// - the return strobe pops the top entry into the counter
// - calls and returns never touch the upper and high latches
// - stack is 31 words of 21 bits; every reset clears pointer
// - pointer zero has no storage, it only marks the empty stack
// - push increments pointer, then writes the new top entry
// - pop copies the top entry to the counter, then decrements
// - stack is off both address spaces; pointer and top are registers
// - software may push and pop through the control register
// - full flag shows pointer reached or passed the 31 levels; underflow flag shows a pop when empty
// - program fetch has its own bus beside data accesses
// - interrupt wake-up with a global enable pushes and loads vector
// - full flag sets on 31st push; only software or power-on clears
// - overflow reset on: 31st push stores counter plus two, resets
// - overflow reset off: pointer stops at 31, entry 31 kept
// - pop when empty loads zero, sets underflow, pointer stays zero
`include "ras_map.vh"

module return_address_stack_unit
#(
	parameter [20:0] MEM_BYTES = `RAS_MEM_32K
)
(
	input wire core_clk,
	input wire srst,
	input wire porRst,
	input wire pcStep,
	input wire jumpValid,
	input wire [20:0] jumpTarget,
	input wire callPush,
	input wire retPop,
	input wire intAck,
	input wire intHighPri,
	input wire wakeIrq,
	input wire globalEnableHighPriority,
	input wire globalEnableLowPriority,
	input wire [2:0] regAddr,
	input wire [7:0] regWrData,
	input wire regWr,
	input wire regRd,
	output wire [7:0] regRdData,
	output wire [20:0] fetchAddr,
	input wire [15:0] memWord,
	output wire [15:0] fetchWord,
	output wire [4:0] stackPtr,
	output wire stackFull,
	output wire stackUnderflow,
	output wire stackResetReq
);

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg [20:0] pc_ff;
	reg [20:0] nxt_pc;
	reg [4:0] ptr_ff;
	reg [4:0] nxt_ptr;
	reg full_ff;
	reg nxt_full;
	reg unf_ff;
	reg nxt_unf;
	reg [7:0] latchHigh_ff;
	reg [7:0] nxt_latchHigh;
	reg [4:0] latchUpper_ff;
	reg [4:0] nxt_latchUpper;
	reg ovfRstEn_ff;
	reg nxt_ovfRstEn;
	reg stackRst_ff;
	reg nxt_stackRst;
	reg [7:0] rdData_ff;
	reg [7:0] nxt_rdData;

	// storage port
	reg stWrEn;
	reg [4:0] stWrIdx;
	reg [20:0] stWrData;
	wire [20:0] topEntry;

	// ----------------------------------------
	// decode of requests
	// ----------------------------------------
	wire intTake;
	wire hwPush;
	wire swPush;
	wire swPop;
	wire anyPush;
	wire ptrWr;
	wire [20:0] intVector;
	wire [20:0] pcPlusTwo;
	wire [4:0] ptrUp;
	wire [4:0] ptrDown;

	// a wake-up counts as an acknowledge only with a global enable set
	assign intTake = intAck | (wakeIrq & (globalEnableHighPriority | globalEnableLowPriority));
	assign intVector = intHighPri ? `RAS_VEC_INT_HIGH : `RAS_VEC_INT_LOW;
	assign hwPush = callPush | intTake;
	assign swPush = regWr & (regAddr == `RAS_OFS_CTRL) & regWrData[`RAS_CTRL_SW_PUSH_BIT];
	assign swPop = regWr & (regAddr == `RAS_OFS_CTRL) & regWrData[`RAS_CTRL_SW_POP_BIT];
	assign anyPush = hwPush | swPush;
	assign ptrWr = regWr & (regAddr == `RAS_OFS_PTR);
	assign pcPlusTwo = pc_ff + `RAS_PC_STEP;
	assign ptrUp = ptr_ff + 5'h01;
	assign ptrDown = ptr_ff - 5'h01;

	// ----------------------------------------
	// stack storage
	// ----------------------------------------
	// storage has no address in program or data space
	stack_storage uStack
	(
		.core_clk(core_clk),
		.wrEn(stWrEn),
		.wrIdx(stWrIdx),
		.wrData(stWrData),
		.rdIdx(ptr_ff),
		.rdData(topEntry)
	);

	// ----------------------------------------
	// fetch path
	// ----------------------------------------
	// fetch address is its own port so data accesses never stall it
	assign fetchAddr = pc_ff;

	fetch_gate #(.MEM_BYTES(MEM_BYTES)) uFetch
	(
		.fetchAddr(pc_ff),
		.memWord(memWord),
		.fetchWord(fetchWord)
	);

	// ----------------------------------------
	// next-state logic
	// ----------------------------------------
	// software register effects first, pushes and pops last so they win a clash; any push, software or hardware, beats a pop
	always @*
	begin
		nxt_pc = pc_ff;
		nxt_ptr = ptr_ff;
		nxt_full = full_ff;
		nxt_unf = unf_ff;
		nxt_latchHigh = latchHigh_ff;
		nxt_latchUpper = latchUpper_ff;
		nxt_ovfRstEn = ovfRstEn_ff;
		nxt_stackRst = 1'b0;
		stWrEn = 1'b0;
		stWrIdx = ptr_ff;
		stWrData = topEntry;

		// pointer write; flag bits may only be cleared by writing zero
		if (ptrWr)
		begin
			nxt_ptr = regWrData[4:0];
			if (!regWrData[`RAS_PTR_FULL_BIT])
				nxt_full = 1'b0;
			if (!regWrData[`RAS_PTR_UNF_BIT])
				nxt_unf = 1'b0;
		end

		// top entry byte writes; ignored while the stack is empty
		if (regWr && (ptr_ff != `RAS_PTR_RST))
		begin
			case (regAddr)
				`RAS_OFS_TOP_LOW:
				begin
					stWrEn = 1'b1;
					stWrData = {topEntry[20:8], regWrData};
				end
				`RAS_OFS_TOP_HIGH:
				begin
					stWrEn = 1'b1;
					stWrData = {topEntry[20:16], regWrData, topEntry[7:0]};
				end
				`RAS_OFS_TOP_UPPER:
				begin
					stWrEn = 1'b1;
					stWrData = {regWrData[4:0], topEntry[15:0]};
				end
				default:
				begin
					stWrEn = 1'b0;
				end
			endcase
		end

		// latch and control writes
		if (regWr && (regAddr == `RAS_OFS_PC_HIGH_LATCH))
			nxt_latchHigh = regWrData;
		if (regWr && (regAddr == `RAS_OFS_PC_UPPER_LATCH))
			nxt_latchUpper = regWrData[4:0];
		if (regWr && (regAddr == `RAS_OFS_CTRL))
			nxt_ovfRstEn = regWrData[`RAS_CTRL_OVF_RST_BIT];

		// reading the low counter byte snapshots the upper bytes into the latches
		if (regRd && (regAddr == `RAS_OFS_PC_LOW))
		begin
			nxt_latchHigh = pc_ff[15:8];
			nxt_latchUpper = pc_ff[20:16];
		end

		// ordinary counter flow; bit 0 stays clear to keep word alignment
		if (regWr && (regAddr == `RAS_OFS_PC_LOW))
			nxt_pc = {latchUpper_ff, latchHigh_ff, regWrData[7:1], 1'b0};
		else if (jumpValid)
			nxt_pc = {jumpTarget[20:1], 1'b0};
		else if (pcStep)
			nxt_pc = pcPlusTwo;

		// push: raise pointer, then write the entry it now selects
		if (anyPush)
		begin
			if (ptr_ff == `RAS_PTR_TOP)
			begin
				// already full: pointer parks and entry 31 is kept
				nxt_ptr = `RAS_PTR_TOP;
				nxt_full = 1'b1;
			end
			else if (ptr_ff == `RAS_PTR_LAST_FREE)
			begin
				stWrEn = 1'b1;
				stWrIdx = `RAS_PTR_TOP;
				nxt_full = 1'b1;
				if (ovfRstEn_ff)
				begin
					stWrData = pcPlusTwo;
					nxt_ptr = `RAS_PTR_RST;
					nxt_stackRst = 1'b1;
				end
				else
				begin
					stWrData = pc_ff;
					nxt_ptr = `RAS_PTR_TOP;
				end
			end
			else
			begin
				stWrEn = 1'b1;
				stWrIdx = ptrUp;
				stWrData = pc_ff;
				nxt_ptr = ptrUp;
			end
			// calls write the counter directly; latches stay as they are
			if (intTake)
				nxt_pc = intVector;
			else if (callPush)
				nxt_pc = {jumpTarget[20:1], 1'b0};
			if (nxt_stackRst)
				nxt_pc = `RAS_VEC_RESET;
		end
		else if (retPop)
		begin
			// pop: copy the top entry out, then lower the pointer
			if (ptr_ff == `RAS_PTR_RST)
			begin
				nxt_pc = `RAS_PC_RST;
				nxt_unf = 1'b1;
				nxt_ptr = `RAS_PTR_RST;
				nxt_stackRst = ovfRstEn_ff;
			end
			else
			begin
				nxt_pc = topEntry;
				nxt_ptr = ptrDown;
			end
		end
		else if (swPop)
		begin
			// software pop only discards the top entry
			if (ptr_ff == `RAS_PTR_RST)
				nxt_unf = 1'b1;
			else
				nxt_ptr = ptrDown;
		end
	end

	// ----------------------------------------
	// register read mux
	// ----------------------------------------
	// data stands only in the cycle after the read strobe
	always @*
	begin
		nxt_rdData = 8'h00;
		if (regRd)
		begin
			case (regAddr)
				`RAS_OFS_PTR: nxt_rdData = {full_ff, unf_ff, 1'b0, ptr_ff};
				`RAS_OFS_TOP_LOW: nxt_rdData = topEntry[7:0];
				`RAS_OFS_TOP_HIGH: nxt_rdData = topEntry[15:8];
				`RAS_OFS_TOP_UPPER: nxt_rdData = {3'h0, topEntry[20:16]};
				`RAS_OFS_PC_LOW: nxt_rdData = pc_ff[7:0];
				`RAS_OFS_PC_HIGH_LATCH: nxt_rdData = latchHigh_ff;
				`RAS_OFS_PC_UPPER_LATCH: nxt_rdData = {3'h0, latchUpper_ff};
				`RAS_OFS_CTRL: nxt_rdData = {7'h00, ovfRstEn_ff};
				default: nxt_rdData = 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// flip-flops
	// ----------------------------------------
	// flags survive the ordinary reset; a set in the same cycle beats a clear
	always @(posedge core_clk)
	begin
		if (porRst)
		begin
			full_ff <= 1'b0;
			unf_ff <= 1'b0;
		end
		else
		begin
			full_ff <= nxt_full;
			unf_ff <= nxt_unf;
		end
	end

	// core state; only srst and porRst reset it, the stack reset request is just an output
	always @(posedge core_clk)
	begin
		if (srst || porRst)
		begin
			pc_ff <= `RAS_PC_RST;
			ptr_ff <= `RAS_PTR_RST;
			latchHigh_ff <= 8'h00;
			latchUpper_ff <= 5'h00;
			ovfRstEn_ff <= `RAS_OVF_RST_EN_RST;
			stackRst_ff <= 1'b0;
			rdData_ff <= 8'h00;
		end
		else
		begin
			pc_ff <= nxt_pc;
			ptr_ff <= nxt_ptr;
			latchHigh_ff <= nxt_latchHigh;
			latchUpper_ff <= nxt_latchUpper;
			ovfRstEn_ff <= nxt_ovfRstEn;
			stackRst_ff <= nxt_stackRst;
			rdData_ff <= nxt_rdData;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign regRdData = rdData_ff;
	assign stackPtr = ptr_ff;
	assign stackFull = full_ff;
	assign stackUnderflow = unf_ff;
	assign stackResetReq = stackRst_ff;

endmodule // return_address_stack_unit

// >>> ras_sva.sv
// checker for the return address stack unit, watching its ports only
// assumes one sequencer strobe per cycle and one core clock
module ras_sva
#(
	parameter [20:0] MEM_BYTES = 21'h008000
)
(
	input logic core_clk,
	input logic srst,
	input logic porRst,
	input logic pcStep,
	input logic jumpValid,
	input logic [20:0] jumpTarget,
	input logic callPush,
	input logic retPop,
	input logic intAck,
	input logic intHighPri,
	input logic wakeIrq,
	input logic globalEnableHighPriority,
	input logic globalEnableLowPriority,
	input logic [2:0] regAddr,
	input logic [7:0] regWrData,
	input logic regWr,
	input logic regRd,
	input logic [7:0] regRdData,
	input logic [20:0] fetchAddr,
	input logic [15:0] memWord,
	input logic [15:0] fetchWord,
	input logic [4:0] stackPtr,
	input logic stackFull,
	input logic stackUnderflow,
	input logic stackResetReq
);
timeunit 1ns;
timeprecision 1ps;
// ----------------------------------------
// properties
// ----------------------------------------
default clocking cb @(posedge core_clk); endclocking
default disable iff (srst || porRst);
// return strobe with no call, acknowledge or wake-up strobe; software strobes are not excluded
wire onlyPop = retPop && !callPush && !intAck && !wakeIrq;
wire intGo = intAck || wakeIrq && (globalEnableHighPriority || globalEnableLowPriority);
sequence s_grown;
	stackPtr == $past(stackPtr) + 5'h01;
endsequence
sequence s_vector;
	fetchAddr == ($past(intHighPri) ? 21'h000008 : 21'h000018);
endsequence
property p_rst;
	disable iff (1'b0) srst || porRst |=> stackPtr == 5'h00 && fetchAddr == 21'h000000;
endproperty
a_rst: assert property (p_rst) else $error("reset left pointer or counter set");
property p_por;
	disable iff (1'b0) porRst |=> !stackFull && !stackUnderflow;
endproperty
a_por: assert property (p_por) else $error("power-on reset kept a flag");
property p_call;
	callPush && stackPtr < 5'h1E |=> s_grown ##0 fetchAddr == {$past(jumpTarget[20:1]), 1'b0};
endproperty
a_call: assert property (p_call) else $error("call push wrong");
property p_int;
	intGo && !callPush && stackPtr < 5'h1E |=> s_grown ##0 s_vector;
endproperty
a_int: assert property (p_int) else $error("interrupt push or vector wrong");
property p_pop;
	onlyPop && stackPtr != 5'h00 |=> stackPtr == $past(stackPtr) - 5'h01;
endproperty
a_pop: assert property (p_pop) else $error("pop pointer wrong");
property p_unf;
	onlyPop && stackPtr == 5'h00 |=> fetchAddr == 21'h000000 && stackUnderflow && stackPtr == 5'h00;
endproperty
a_unf: assert property (p_unf) else $error("empty pop wrong");
property p_stop;
	stackPtr == 5'h1F && (callPush || intAck) |=> stackPtr == 5'h1F && stackFull;
endproperty
a_stop: assert property (p_stop) else $error("pointer moved past top");
property p_full;
	disable iff (porRst) stackFull && !(regWr && regAddr == 3'h0 && !regWrData[7]) |=> stackFull;
endproperty
a_full: assert property (p_full) else $error("full flag dropped");
property p_rstreq;
	stackResetReq |-> stackPtr == 5'h00 && fetchAddr == 21'h000000 && (stackFull || stackUnderflow);
endproperty
a_rstreq: assert property (p_rstreq) else $error("stack reset state wrong");
property p_fetch;
	fetchWord == (fetchAddr < MEM_BYTES ? memWord : 16'h0000);
endproperty
a_fetch: assert property (p_fetch) else $error("fetch word wrong");
property p_rdptr;
	regRd && regAddr == 3'h0 |=> regRdData == {$past(stackFull), $past(stackUnderflow), 1'b0, $past(stackPtr)};
endproperty
a_rdptr: assert property (p_rdptr) else $error("pointer read wrong");
property p_step;
	pcStep && !jumpValid && !intGo && !callPush && !retPop && !regWr |=> fetchAddr == $past(fetchAddr) + 21'h000002;
endproperty
a_step: assert property (p_step) else $error("step wrong");
endmodule // ras_sva
bind return_address_stack_unit ras_sva #(.MEM_BYTES(MEM_BYTES)) u_sva (.*);

// >>> seq_model.sv
// instruction sequencer model: one strobe per request, plus program memory
// assumes the bench calls issue from a single process
module seq_model
(
	input logic core_clk,
	input logic [20:0] fetchAddr,
	output logic [15:0] memWord,
	output logic pcStep,
	output logic jumpValid,
	output logic [20:0] jumpTarget,
	output logic callPush,
	output logic retPop,
	output logic intAck,
	output logic intHighPri,
	output logic wakeIrq,
	output logic globalEnableHighPriority,
	output logic globalEnableLowPriority
);
timeunit 1ns;
timeprecision 1ps;
// memory on its own bus; every word is nonzero so a zero fetch stands out
assign memWord = {1'b1, fetchAddr[15:1]};
initial
begin
	{pcStep, jumpValid, callPush, retPop, intAck, intHighPri, wakeIrq} = 7'h00;
	{globalEnableHighPriority, globalEnableLowPriority} = 2'h0;
	jumpTarget = 21'h000000;
end
// ops: 0 step 1 jump 2 call 3 return 4/5 interrupt high/low 6 wake enabled 7 wake masked
task issue(input logic [2:0] op, input logic [20:0] t);
	@(posedge core_clk);
	pcStep <= op == 3'h0;
	jumpValid <= op == 3'h1;
	callPush <= op == 3'h2;
	retPop <= op == 3'h3;
	intAck <= op == 3'h4 || op == 3'h5;
	intHighPri <= op != 3'h5;
	wakeIrq <= op[2] & op[1];
	globalEnableLowPriority <= op == 3'h6;
	globalEnableHighPriority <= op == 3'h4;
	jumpTarget <= t;
	@(posedge core_clk);
	{pcStep, jumpValid, callPush, retPop, intAck, wakeIrq} <= 6'h00;
	jumpTarget <= ~t; // target is meaningless between requests
endtask
endmodule // seq_model

// >>> tb_return_address_stack_unit.sv
// bench for the return address stack unit with the 16-Kbyte memory option
// assumes seq_model drives the sequencer side and ras_sva is bound
module tb_return_address_stack_unit;
timeunit 1ns;
timeprecision 1ps;
logic core_clk = 1'b0;
logic srst = 1'b1;
logic porRst = 1'b1;
logic regWr = 1'b0;
logic regRd = 1'b0;
logic [2:0] regAddr = 3'h0;
logic [7:0] regWrData = 8'h00;
logic [7:0] regRdData;
logic [20:0] fetchAddr;
logic [20:0] jumpTarget;
logic [20:0] e;
logic [15:0] memWord;
logic [15:0] fetchWord;
logic [4:0] stackPtr;
logic stackFull, stackUnderflow, stackResetReq, pcStep, jumpValid, callPush, retPop;
logic intAck, intHighPri, wakeIrq, globalEnableHighPriority, globalEnableLowPriority;
logic [7:0] rv;
logic [49:0] rows [15];
int fails = 0;
int checksDone = 0;
always #5 core_clk = ~core_clk;
seq_model SEQ (.*);
return_address_stack_unit #(.MEM_BYTES(21'h004000)) DUT (.*);
// ----------------------------------------
// tasks
// ----------------------------------------
task cv(input logic [20:0] g, input logic [20:0] x);
	checksDone++;
	if (g !== x)
	begin
		fails++;
		$display("mismatch at %0t: got %h expected %h", $time, g, x);
	end
endtask
task wr(input logic [2:0] a, input logic [7:0] d);
	@(posedge core_clk);
	regAddr <= a;
	regWrData <= d;
	regWr <= 1'b1;
	@(posedge core_clk);
	regWr <= 1'b0;
	#1;
endtask
task rd(input logic [2:0] a, input logic [7:0] x);
	@(posedge core_clk);
	regAddr <= a;
	regRd <= 1'b1;
	@(posedge core_clk);
	regRd <= 1'b0;
	#1 rv = regRdData;
	cv({13'h0000, rv}, {13'h0000, x});
endtask
task op(input logic [2:0] o, input logic [20:0] t);
	SEQ.issue(o, t);
	#1;
endtask
// flags and pointer packed as {underflow, reset request, full, pointer}
task st(input logic [20:0] x);
	cv({13'h0000, stackUnderflow, stackResetReq, stackFull, stackPtr}, x);
endtask
task rst(input logic p);
	@(posedge core_clk);
	porRst <= p;
	srst <= !p;
	@(posedge core_clk);
	{srst, porRst} <= 2'h0;
endtask
task close_out;
	$display("checks %0d mismatches %0d", checksDone, fails);
	if (fails == 0 && checksDone > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
// ----------------------------------------
// main sequence
// ----------------------------------------
initial
begin
	// rows: op, target, counter after, pointer after
	rows = '{{3'h2, 21'h000100, 21'h000100, 5'h01}, {3'h2, 21'h000200, 21'h000200, 5'h02},
		{3'h4, 21'h000000, 21'h000008, 5'h03}, {3'h5, 21'h000000, 21'h000018, 5'h04},
		{3'h6, 21'h000000, 21'h000008, 5'h05}, {3'h7, 21'h000000, 21'h000008, 5'h05},
		{3'h3, 21'h000000, 21'h000018, 5'h04}, {3'h3, 21'h000000, 21'h000008, 5'h03},
		{3'h3, 21'h000000, 21'h000200, 5'h02}, {3'h0, 21'h000000, 21'h000202, 5'h02},
		{3'h1, 21'h003FFF, 21'h003FFE, 5'h02}, {3'h0, 21'h000000, 21'h004000, 5'h02},
		{3'h1, 21'h1FFFFE, 21'h1FFFFE, 5'h02}, {3'h3, 21'h000000, 21'h000100, 5'h01},
		{3'h3, 21'h000000, 21'h000000, 5'h00}};
	repeat (4) @(posedge core_clk);
	{srst, porRst} <= 2'h0;
	#1 st(21'h000000);
	foreach (rows[i])
	begin
		op(rows[i][49:47], rows[i][46:26]);
		e = rows[i][25:5];
		cv(fetchAddr, e);
		cv({16'h0000, stackPtr}, {16'h0000, rows[i][4:0]});
		cv({5'h00, fetchWord}, e < 21'h004000 ? {6'h01, e[15:1]} : 21'h000000);
	end
	op(3'h1, 21'h012344);
	wr(3'h0, 8'h03);
	op(3'h2, 21'h000300);
	st(21'h000004);
	rd(3'h1, 8'h44);
	rd(3'h2, 8'h23);
	rd(3'h3, 8'h01);
	wr(3'h1, 8'h56);
	op(3'h3, 21'h000000);
	cv(fetchAddr, 21'h012356);
	wr(3'h7, 8'h03);
	st(21'h000004);
	rd(3'h1, 8'h56);
	wr(3'h7, 8'h05);
	st(21'h000003);
	// latches must survive a call and a return
	wr(3'h5, 8'h7A);
	wr(3'h6, 8'h01);
	op(3'h2, 21'h000400);
	op(3'h3, 21'h000000);
	rd(3'h5, 8'h7A);
	rd(3'h6, 8'h01);
	wr(3'h4, 8'h10);
	cv(fetchAddr, 21'h017A10);
	// overflow with reset enabled from the default
	wr(3'h0, 8'h1E);
	op(3'h2, 21'h000500);
	st(21'h000060);
	wr(3'h0, 8'h9F);
	rd(3'h1, 8'h12);
	rd(3'h0, 8'h9F);
	rst(1'b0);
	rd(3'h0, 8'h80);
	rst(1'b1);
	rd(3'h0, 8'h00);
	// overflow with reset disabled: pointer parks at the top
	wr(3'h7, 8'h00);
	wr(3'h0, 8'h1E);
	op(3'h1, 21'h000664);
	op(3'h2, 21'h000700);
	st(21'h00003F);
	op(3'h2, 21'h000800);
	st(21'h00003F);
	rd(3'h1, 8'h64);
	wr(3'h0, 8'h00);
	op(3'h3, 21'h000000);
	cv(fetchAddr, 21'h000000);
	st(21'h000080);
	rd(3'h0, 8'h40);
	wr(3'h0, 8'h00);
	rd(3'h0, 8'h00);
	rd(3'h1, 8'h00);
	close_out;
end
endmodule // tb_return_address_stack_unit
